// ### ctrl_serial_port_pkg.sv
// Purpose: Shared constants and types for the serial control port
// Assumes: Both ends run on mclk at 20 MHz
// Notes:   Command words and data words travel MSB first
package ctrl_serial_port_pkg;

  localparam int          WORD_BITS   = 16;
  localparam logic [3:0]  OP_STATUS   = 4'h3;
  localparam logic [3:0]  OP_REG_RD   = 4'h5;
  localparam logic [3:0]  OP_REG_WR   = 4'h4;
  localparam logic [3:0]  OP_CFG_RD   = 4'h7;
  localparam logic [3:0]  OP_CFG_WR   = 4'h6;
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam int          RDY_BIT     = 15;
  localparam int          INT_BIT     = 14;
  localparam logic [7:0]  CFG_RST     = 8'h00;
  localparam int          CLK_DIV     = 4;
  localparam logic [4:0]  BIT_CNT_RST = 5'h00;

  typedef enum logic [2:0]
  {
    PH_IDLE   = 3'b000,
    PH_CMD    = 3'b001,
    PH_STATUS = 3'b010,
    PH_DATA   = 3'b011,
    PH_WDATA  = 3'b100,
    PH_DONE   = 3'b101
  } phase_t;

  typedef enum logic [2:0]
  {
    AC_NONE   = 3'b000,
    AC_STATUS = 3'b001,
    AC_REG_RD = 3'b010,
    AC_REG_WR = 3'b011,
    AC_CFG_RD = 3'b100,
    AC_CFG_WR = 3'b101
  } access_t;

  // Classify a command word; anything unmatched is reserved
  function automatic access_t decode_cmd(input logic [15:0] w);
    access_t a;
    a = AC_NONE;
    case (w[15:12])
      OP_STATUS: a = (w[11:0] == 12'h000) ? AC_STATUS : AC_NONE;
      OP_REG_RD: a = AC_REG_RD;
      OP_REG_WR: a = AC_REG_WR;
      OP_CFG_RD: a = (w[11:1] == 11'h000) ? AC_CFG_RD : AC_NONE;
      OP_CFG_WR: a = (w[11:10] == 2'h0) ? AC_CFG_WR : AC_NONE;
      default:   a = AC_NONE;
    endcase
    return a;
  endfunction : decode_cmd

endpackage : ctrl_serial_port_pkg

// ### ctrl_serial_port_if.sv
// Purpose: Four-wire link between host and device
// Assumes: Bench resolves the shared output line from its enable
// Notes:   No clocking block
interface ctrl_serial_port_if;
  logic csN;
  logic sclk;
  logic serialCmdIn;
  logic serialRespOut;
  logic serialRespOutEn;
  logic intN;

  modport device
  (
    input  csN,
    input  sclk,
    input  serialCmdIn,
    output serialRespOut,
    output serialRespOutEn,
    output intN
  );

  modport host
  (
    output csN,
    output sclk,
    output serialCmdIn,
    input  serialRespOut,
    input  serialRespOutEn,
    input  intN
  );
endinterface : ctrl_serial_port_if

// ### ctrl_serial_port_dev.sv
// Purpose: Device end of the serial control port
// Assumes: Link pins are asynchronous to mclk and pass two flip-flops
// Notes:   Register file behind the port is exposed on user-side ports
//
// How it works
// - Select falling edge starts a command word
// - Sample on rising, shift on falling clock
// - Select rising edge ends the access
// - Power-down status shows only ready valid
// - After status host may continue reading data
// - Host waits for ready before register access
// - Every access opens with 16-bit command
// - Config write data in command, then end
// - Register read command ends after command
// - Other accesses shift status after command
// - Register write takes one more data word
// - Even config read registers 0-1, odd registers 2-3
// - Internal interrupt clears at first status bit
// - Interrupt output masked while select low
// - Pending interrupt reasserts when select rises
// - Command encodings in top four bits
// - Config write: 0110, 00, target, data
// - Bits 9:8 choose config register 0-3
// - Bit 0 chooses config register pair
// - Reserved command words are ignored
//
// The implementer's own choices: the register offsets and strobed register access.
module ctrl_serial_port_dev
(
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  ctrl_serial_port_if.device        link,
  input  wire logic                 powerDown,
  input  wire logic                 ready,
  input  wire logic [13:0]          statusBits,
  input  wire logic                 intEvent,
  input  wire logic [15:0]          readData,
  output logic                      readNext,
  output logic                      regRdStrobe,
  output logic                      regWrStrobe,
  output logic [11:0]               regIndex,
  output logic [15:0]               regWrData,
  output logic [31:0]               hwSetupRegs
);
  import ctrl_serial_port_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  csS;
    logic [2:0]  clkS;
    logic [1:0]  dinS;
    phase_t      phase;
    access_t     acc;
    logic [4:0]  bitCnt;
    logic [15:0] shIn;
    logic [15:0] shOut;
    logic [11:0] idx;
    logic        pair;
    logic        intPend;
    logic        respOut;
    logic        respEn;
    logic        intN;
    logic        readNext;
    logic        rdStb;
    logic        wrStb;
    logic [11:0] regIndex;
    logic [15:0] wrData;
    logic [31:0] cfg;
  } dev_state_t;

  dev_state_t q, d;

  logic        csLow;
  logic        csFall;
  logic        csRise;
  logic        clkRise;
  logic        clkFall;
  logic        din;
  logic [15:0] cmdWord;
  logic [15:0] statusWord;
  logic [15:0] cfgPair;

  // Bit 1 of each sampler is the second stage; bit 2 only serves edge detection
  assign csLow   = ~q.csS[1];
  assign csFall  = q.csS[2] & ~q.csS[1];
  assign csRise  = ~q.csS[2] & q.csS[1];
  assign clkRise = ~q.clkS[2] & q.clkS[1];
  assign clkFall = q.clkS[2] & ~q.clkS[1];
  assign din     = q.dinS[1];
  assign cmdWord = {q.shIn[14:0], din};
  // While powered down only ready is trustworthy, the rest is forced low
  assign statusWord = powerDown ? {ready, 15'h0000}
                                : {ready, q.intPend, statusBits};
  assign cfgPair = q.pair ? q.cfg[31:16] : q.cfg[15:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d          = q;
    d.csS      = {q.csS[1:0], link.csN};
    d.clkS     = {q.clkS[1:0], link.sclk};
    d.dinS     = {q.dinS[0], link.serialCmdIn};
    d.rdStb    = 1'b0;
    d.wrStb    = 1'b0;
    d.readNext = 1'b0;
    if (intEvent)
    begin
      d.intPend = 1'b1;
    end
    if (csFall)
    begin
      d.phase  = PH_CMD;
      d.bitCnt = BIT_CNT_RST;
    end
    else if (csRise || !csLow)
    begin
      d.phase  = PH_IDLE;
      d.respEn = 1'b0;
    end
    else
    begin
      if (clkRise && (q.phase == PH_CMD || q.phase == PH_WDATA))
      begin
        d.shIn   = {q.shIn[14:0], din};
        d.bitCnt = q.bitCnt + 5'h01;
        if (q.bitCnt == 5'(WORD_BITS - 1))
        begin
          d.bitCnt = BIT_CNT_RST;
          if (q.phase == PH_WDATA)
          begin
            d.wrStb  = 1'b1;
            d.wrData = cmdWord;
            d.phase  = PH_DONE;
          end
          else
          begin
            d.acc = decode_cmd(cmdWord);
            d.idx = cmdWord[11:0];
            d.pair = cmdWord[0];
            case (decode_cmd(cmdWord))
              AC_CFG_WR:
              begin
                d.cfg[8 * cmdWord[9:8] +: 8] = cmdWord[7:0];
                d.phase = PH_DONE;
              end
              AC_REG_RD:
              begin
                d.rdStb    = 1'b1;
                d.regIndex = cmdWord[11:0];
                d.phase    = PH_DONE;
              end
              AC_NONE:   d.phase = PH_DONE;
              default:   d.phase = PH_STATUS;
            endcase
          end
        end
      end
      else if (clkFall && q.phase == PH_STATUS && q.bitCnt == BIT_CNT_RST && q.respEn == 1'b0)
      begin
        // First status bit goes out; the request is consumed here
        d.shOut   = {statusWord[14:0], 1'b0};
        d.respOut = statusWord[15];
        d.respEn  = 1'b1;
        d.intPend = intEvent;
        d.bitCnt  = 5'h01;
      end
      else if (clkFall && (q.phase == PH_STATUS || q.phase == PH_DATA) && q.respEn)
      begin
        if (q.bitCnt == 5'(WORD_BITS))
        begin
          d.bitCnt = 5'h01;
          case (q.acc)
            AC_REG_WR:
            begin
              d.respEn   = 1'b0;
              d.regIndex = q.idx;
              d.phase    = PH_WDATA;
              d.bitCnt   = BIT_CNT_RST;
            end
            AC_CFG_RD:
            begin
              d.respOut = cfgPair[15];
              d.shOut   = {cfgPair[14:0], 1'b0};
              d.phase   = PH_DATA;
            end
            default:
            begin
              // Further data words stream while the host clocks
              d.respOut  = readData[15];
              d.shOut    = {readData[14:0], 1'b0};
              d.readNext = 1'b1;
              d.phase    = PH_DATA;
            end
          endcase
        end
        else
        begin
          d.respOut = q.shOut[15];
          d.shOut   = {q.shOut[14:0], 1'b0};
          d.bitCnt  = q.bitCnt + 5'h01;
        end
      end
    end
    d.intN = csLow ? 1'b1 : ~d.intPend;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q          <= '0;
      q.csS      <= 3'h7;
      // Shift clock idles low; a high reset value would fake a falling edge
      q.clkS     <= 3'h0;
      q.phase    <= PH_IDLE;
      q.acc      <= AC_NONE;
      q.intN     <= 1'b1;
      q.cfg      <= {4{CFG_RST}};
    end
    else
    begin
      q <= d;
    end
  end

  assign link.serialRespOut   = q.respOut;
  assign link.serialRespOutEn = q.respEn;
  assign link.intN            = q.intN;
  assign readNext             = q.readNext;
  assign regRdStrobe          = q.rdStb;
  assign regWrStrobe          = q.wrStb;
  assign regIndex             = q.regIndex;
  assign regWrData            = q.wrData;
  assign hwSetupRegs          = q.cfg;

endmodule : ctrl_serial_port_dev

// ### ctrl_serial_port_host.sv
// Purpose: Host end of the serial control port, driven by a command port
// Assumes: Device samples sclk with two flip-flops on its own mclk
// Notes:   sclk is mclk divided; one bit per CLK_DIV*2 mclk cycles
module ctrl_serial_port_host
(
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  ctrl_serial_port_if.host          link,
  input  wire logic [3:0]           addr,
  input  wire logic [15:0]          wrData,
  input  wire logic                 wrStrobe,
  input  wire logic                 rdStrobe,
  output logic [15:0]               rdData
);
  import ctrl_serial_port_pkg::*;

  // ----------------------------------------------------------------
  // Own registers: 0 command, 1 write data, 2 words to read, 3 go,
  // 4 status (busy, intN), 5 status word, 6 data word
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_WD  = 4'h1;
  localparam logic [3:0] A_NRD = 4'h2;
  localparam logic [3:0] A_GO  = 4'h3;
  localparam logic [3:0] A_ST  = 4'h4;
  localparam logic [3:0] A_SW  = 4'h5;
  localparam logic [3:0] A_DW  = 4'h6;

  typedef struct packed {
    logic [1:0]  intS;
    logic [15:0] cmd;
    logic [15:0] wd;
    logic [3:0]  nRd;
    logic        busy;
    logic [2:0]  div;
    logic        sclk;
    logic        csN;
    logic        sdo;
    logic [1:0]  sinS;
    logic [5:0]  bits;
    logic [15:0] sh;
    logic [15:0] stWord;
    logic [15:0] dWord;
    logic [4:0]  wordCnt;
    logic [4:0]  words;
    logic [15:0] rd;
  } host_state_t;

  host_state_t q, d;
  access_t     acc;
  logic        rdBit;

  assign acc   = decode_cmd(q.cmd);
  assign rdBit = q.sinS[1];

  always_comb
  begin
    d      = q;
    d.intS = {q.intS[0], link.intN};
    d.sinS = {q.sinS[0], link.serialRespOut};
    d.rd   = 16'h0000;
    if (wrStrobe && !q.busy)
    begin
      case (addr)
        A_CMD: d.cmd = wrData;
        A_WD:  d.wd  = wrData;
        A_NRD: d.nRd = wrData[3:0];
        A_GO:
        begin
          // Register accesses wait for a status word that showed ready
          if (q.stWord[RDY_BIT] || (acc != AC_REG_RD && acc != AC_REG_WR))
          begin
            // Total words: command, then status/data or write data per class
            d.busy    = 1'b1;
            d.csN     = 1'b0;
            d.sh      = q.cmd;
            d.sdo     = q.cmd[15];
            d.bits    = 6'h00;
            d.wordCnt = 5'h00;
            d.div     = 3'h0;
            case (acc)
              AC_CFG_WR, AC_REG_RD, AC_NONE: d.words = 5'h01;
              AC_REG_WR:                     d.words = 5'h03;
              default:                       d.words = 5'(q.nRd) + 5'h02;
            endcase
          end
        end
        default: ;
      endcase
    end
    if (rdStrobe)
    begin
      case (addr)
        A_CMD:   d.rd = q.cmd;
        A_WD:    d.rd = q.wd;
        A_NRD:   d.rd = {12'h000, q.nRd};
        A_ST:    d.rd = {14'h0000, q.intS[1], q.busy};
        A_SW:    d.rd = q.stWord;
        A_DW:    d.rd = q.dWord;
        default: d.rd = 16'h0000;
      endcase
    end
    if (q.busy && !q.csN)
    begin
      d.div = q.div + 3'h1;
      if (q.div == 3'(CLK_DIV - 1))
      begin
        d.div  = 3'h0;
        d.sclk = ~q.sclk;
        if (q.sclk)
        begin
          // Falling edge: the reply bit needs five mclk through both syncs,
          // more than half a bit, so it is taken here; next bit goes out
          d.bits = q.bits + 6'h01;
          d.sh   = {q.sh[14:0], rdBit};
          d.sdo  = q.sh[14];
          if (q.bits == 6'(WORD_BITS - 1))
          begin
            d.bits    = 6'h00;
            d.wordCnt = q.wordCnt + 5'h01;
            if (q.wordCnt == 5'h01)
            begin
              d.stWord = {q.sh[14:0], rdBit};
            end
            else if (q.wordCnt > 5'h01)
            begin
              d.dWord = {q.sh[14:0], rdBit};
            end
            d.sh  = (q.wordCnt == 5'h01 && acc == AC_REG_WR) ? q.wd : 16'h0000;
            d.sdo = (q.wordCnt == 5'h01 && acc == AC_REG_WR) ? q.wd[15] : 1'b0;
            if (q.wordCnt + 5'h01 == q.words)
            begin
              d.csN = 1'b1;
            end
          end
        end
      end
    end
    else if (q.csN && q.busy)
    begin
      d.busy = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q      <= '0;
      q.intS <= 2'h3;
      q.csN  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.csN        = q.csN;
  assign link.sclk       = q.sclk;
  assign link.serialCmdIn = q.sdo;
  assign rdData          = q.rd;

endmodule : ctrl_serial_port_host

// ### ctrl_serial_port_assertions.sv
// Purpose: Link checks for the serial control port
// Assumes: Both ends on mclk, sclk high and low for 4 mclk each
// Notes:   Sees only the shared link signals
module ctrl_serial_port_assertions
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic serialCmdIn,
  input wire logic serialRespOut,
  input wire logic serialRespOutEn,
  input wire logic intN
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] riseCnt_q;
  logic       sclkPrev_q;

  // ----------------------------------------
  // Shift clock rises within one select phase
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      riseCnt_q  <= 8'h00;
      sclkPrev_q <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= sclk;
      if (csN)
        riseCnt_q <= 8'h00;
      else if (sclk && !sclkPrev_q)
        riseCnt_q <= riseCnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence sclkHighPhase;
    sclk[*4] ##1 !sclk;
  endsequence
  // Sync delay of the device: allow a few cycles before the mask holds
  sequence selectHeld;
    !csN[*6];
  endsequence

  chk_int_masked: assert property (selectHeld |-> intN)
    else $error("interrupt line active while selected");
  chk_sclk_period: assert property ($rose(sclk) |-> sclkHighPhase)
    else $error("shift clock high phase wrong");
  chk_sclk_idle: assert property (csN && $past(csN) |-> !sclk)
    else $error("shift clock not idle low");
  chk_cmd_stable: assert property (!csN && sclk && $past(sclk) |-> $stable(serialCmdIn))
    else $error("command bit moved while clock high");
  chk_resp_stable: assert property (serialRespOutEn && $past(serialRespOutEn)
    && sclk && $past(sclk) |-> $stable(serialRespOut))
    else $error("response bit moved while clock high");
  chk_whole_words: assert property ($rose(csN) |->
    riseCnt_q != 8'h00 && riseCnt_q[3:0] == 4'h0)
    else $error("access not a whole number of words");
  chk_en_after_cmd: assert property ($rose(serialRespOutEn) |-> riseCnt_q == 8'h10)
    else $error("response driven outside status phase");
  chk_en_release: assert property ($rose(csN) |-> ##[1:6] !serialRespOutEn)
    else $error("response still driven after deselect");
endmodule : ctrl_serial_port_assertions

// ### serial_control_port_bench.sv
// Purpose: Bench for host and device ends of the serial control port
// Assumes: Host regs 0 cmd, 1 data, 2 words, 3 go, 4 busy, 5 status, 6 data
// Notes:   Reserved commands only checked for having no effect
module serial_control_port_bench;
  import ctrl_serial_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] wd;
    logic [1:0]  nRd;
    logic [2:0]  sel;
    logic [7:0]  bits;
    logic [31:0] exp;
  } row_t;

  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wrData = 16'h0000;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  logic [15:0] rdData;
  logic        powerDown = 1'b0;
  logic        ready = 1'b1;
  logic        intEvent = 1'b0;
  logic        readNext;
  logic        regRdStrobe;
  logic        regWrStrobe;
  logic [11:0] regIndex;
  logic [15:0] regWrData;
  logic [31:0] hwSetupRegs;
  logic [31:0] wrSeen = 32'h0;
  logic [31:0] rdSeen = 32'h0;
  logic [7:0]  nextCnt = 8'h00;
  logic [7:0]  bitCnt = 8'h00;
  logic        sclkQ = 1'b0;
  logic        csQ = 1'b1;
  logic [15:0] v;
  logic [31:0] got;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  row_t        rows [14];

  ctrl_serial_port_if link();

  ctrl_serial_port_host i_ctrl_serial_port_host
  (
    .mclk(mclk), .rstn(rstn), .link(link), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData)
  );
  ctrl_serial_port_dev i_ctrl_serial_port_dev
  (
    .mclk(mclk), .rstn(rstn), .link(link), .powerDown(powerDown), .ready(ready),
    .statusBits(14'h1A5C), .intEvent(intEvent), .readData(16'hC3A5),
    .readNext(readNext), .regRdStrobe(regRdStrobe), .regWrStrobe(regWrStrobe),
    .regIndex(regIndex), .regWrData(regWrData), .hwSetupRegs(hwSetupRegs)
  );
  ctrl_serial_port_assertions i_ctrl_serial_port_assertions
  (
    .mclk(mclk), .rstn(rstn), .csN(link.csN), .sclk(link.sclk),
    .serialCmdIn(link.serialCmdIn), .serialRespOut(link.serialRespOut),
    .serialRespOutEn(link.serialRespOutEn), .intN(link.intN)
  );

  // ----------------------------------------
  // Clock, watchdog and link monitors
  // ----------------------------------------
  always #25 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    sclkQ <= link.sclk;
    csQ   <= link.csN;
    if (csQ && !link.csN)
      bitCnt <= 8'h00;
    else if (!link.csN && link.sclk && !sclkQ)
      bitCnt <= bitCnt + 8'h01;
    if (regWrStrobe)
      wrSeen <= {4'h0, regIndex, regWrData};
    if (regRdStrobe)
      rdSeen <= {20'h0, regIndex};
    if (readNext)
      nextCnt <= nextCnt + 8'h01;
    // Generous ceiling: about 25 accesses of at most 700 cycles each
    if (cycles == 60000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    @(negedge mclk);
    d = rdData;
  endtask : rd

  task automatic waitIdle;
    logic [15:0] b;
    b = 16'hFFFF;
    for (int k = 0; k < 600 && b[0] !== 1'b0; k++)
      rd(4'h4, b);
    chk({31'h0, b[0]}, 32'h0);
  endtask : waitIdle

  task automatic start(input logic [15:0] c, input logic [15:0] d, input logic [1:0] n);
    wr(4'h0, c);
    wr(4'h1, d);
    wr(4'h2, {14'h0, n});
    wr(4'h3, 16'h0001);
  endtask : start

  task automatic tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Sequence of tests
  // ----------------------------------------
  initial
  begin
    rows = '{
      '{16'h6011, 16'h0, 2'd0, 3'd0, 8'd16, 32'h00000011},
      '{16'h6122, 16'h0, 2'd0, 3'd0, 8'd16, 32'h00002211},
      '{16'h6233, 16'h0, 2'd0, 3'd0, 8'd16, 32'h00332211},
      '{16'h6344, 16'h0, 2'd0, 3'd0, 8'd16, 32'h44332211},
      '{16'h7000, 16'h0, 2'd1, 3'd1, 8'd48, 32'h00002211},
      '{16'h7001, 16'h0, 2'd1, 3'd1, 8'd48, 32'h00004433},
      '{16'h3000, 16'h0, 2'd0, 3'd2, 8'd32, 32'h00009A5C},
      '{16'h3000, 16'h0, 2'd2, 3'd1, 8'd64, 32'h0000C3A5},
      '{16'h4ABC, 16'h1234, 2'd0, 3'd3, 8'd48, 32'h0ABC1234},
      '{16'h5123, 16'h0, 2'd0, 3'd4, 8'd16, 32'h00000123},
      '{16'h3001, 16'h0, 2'd0, 3'd0, 8'd0, 32'h44332211},
      '{16'h7002, 16'h0, 2'd0, 3'd0, 8'd0, 32'h44332211},
      '{16'h6400, 16'h0, 2'd0, 3'd0, 8'd0, 32'h44332211},
      '{16'hF0FF, 16'h0, 2'd0, 3'd0, 8'd0, 32'h44332211}};
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      start(rows[i].cmd, rows[i].wd, rows[i].nRd);
      waitIdle();
      case (rows[i].sel)
        3'd0: got = hwSetupRegs;
        3'd1: begin rd(4'h6, v); got = {16'h0, v}; end
        3'd2: begin rd(4'h5, v); got = {16'h0, v}; end
        3'd3: got = wrSeen;
        default: got = rdSeen;
      endcase
      chk(got, rows[i].exp);
      if (rows[i].bits != 8'd0)
        chk({24'h0, bitCnt}, {24'h0, rows[i].bits});
      $display("row %0d done", i);
    end
    // Only the two extra words of the streamed status read take data words
    chk({24'h0, nextCnt}, 32'h00000002);
    // Interrupt raised, cleared by a status read, re-raised mid-read
    @(posedge mclk) intEvent <= 1'b1;
    @(posedge mclk) intEvent <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({31'h0, link.intN}, 32'h0);
    start(16'h3000, 16'h0, 2'd0);
    waitIdle();
    rd(4'h5, v);
    chk({31'h0, v[INT_BIT]}, 32'h1);
    chk({31'h0, link.intN}, 32'h1);
    start(16'h3000, 16'h0, 2'd0);
    for (int k = 0; k < 400 && link.serialRespOutEn !== 1'b1; k++)
      @(posedge mclk);
    intEvent <= 1'b1;
    @(posedge mclk) intEvent <= 1'b0;
    waitIdle();
    chk({31'h0, link.intN}, 32'h0);
    start(16'h3000, 16'h0, 2'd0);
    waitIdle();
    $display("interrupt test done");
    // Power-down: only the ready bit counts
    @(posedge mclk) powerDown <= 1'b1;
    for (int r = 1; r >= 0; r--)
    begin
      @(posedge mclk) ready <= r[0];
      start(16'h3000, 16'h0, 2'd0);
      waitIdle();
      rd(4'h5, v);
      chk({31'h0, v[RDY_BIT]}, {31'h0, r[0]});
    end
    // Last status showed not ready, so the host must hold back a register read
    start(16'h5456, 16'h0, 2'd0);
    waitIdle();
    chk(rdSeen, 32'h00000123);
    @(posedge mclk) powerDown <= 1'b0;
    ready     <= 1'b1;
    $display("power-down test done");
    // Reset in mid-run returns the link to idle
    @(posedge mclk) rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(hwSetupRegs, {4{CFG_RST}});
    chk({28'h0, link.csN, link.sclk, link.intN, link.serialRespOutEn}, 32'hA);
    rstn <= 1'b1;
    // The link must carry a clean status read straight after the release
    start(16'h3000, 16'h0, 2'd0);
    waitIdle();
    rd(4'h5, v);
    chk({16'h0, v}, 32'h00009A5C);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : serial_control_port_bench
